// >>> psc_pattern_sequencer_control.v
// Pattern sequencer control core: address stepping, states, clocking
`include "psc_defs.vh"

// Functional notes
// R1: Continuous mode wraps window until stop/break
// R2: Single mode runs window once, halts
// R3: Single mode: each run edge one pass
// R4: Gated: run while gate true, finish window
// R5: Gated modes ignore the run key
// R6: Preload repeat: zero to start, then cycle
// R7: Preload gated: gate starts, stops at end
// R8: Other modes start on key or edge
// R9: Gated modes disable all break functions
// R10: Strobe-break: strobe one enters break
// R11: Clock one keeps toggling in break
// R12: Internal clock rate programmable by divider
// R13: External clock on rising or falling edge
// R14: Manual keys step one address each
// R15: Run input off, rising or falling
// R16: Stop input off, rising or falling
// R17: Break input off, rising or falling
// R18: Strobe data mode gives strobe bit
// R19: Strobe clock mode gives narrow pulse
// R20: Start from stop at window start
// R21: Start from break at current address
// R22: Stop holds last word on outputs
// R23: Rear inputs synchronised, acted once
module psc_pattern_sequencer_control (
	input  wire                   i_clk,
	input  wire                   i_rst,
	input  wire                   i_ce,
	input  wire [2:0]             i_cycle_mode,
	input  wire [1:0]             i_clock_source,
	input  wire [`PSC_DIV_W-1:0]  i_int_divide,
	input  wire [`PSC_AW-1:0]     i_window_start_address,
	input  wire [`PSC_AW-1:0]     i_window_end_address,
	input  wire                   i_strobe_break_en,
	input  wire                   i_clock_one_in_break,
	input  wire                   i_strobe_clock_mode,
	input  wire [1:0]             i_run_sense,
	input  wire [1:0]             i_stop_sense,
	input  wire [1:0]             i_break_sense,
	input  wire                   i_run_input,
	input  wire                   i_stop_input,
	input  wire                   i_break_input,
	input  wire                   i_outside_clock_input,
	input  wire                   i_run_key,
	input  wire                   i_stop_key,
	input  wire                   i_break_key,
	input  wire                   i_step_ahead_key,
	input  wire                   i_step_back_key,
	input  wire                   i_strobe_bit,
	output reg  [`PSC_AW-1:0]     o_address,
	output reg  [1:0]             o_state,
	output reg                    o_clock_one,
	output reg                    o_clock_two,
	output reg                    o_strobe_out
);

	// Edge qualification, used for run, stop and break inputs
	function edge_hit;
		input [1:0] sense;
		input       cur;
		input       prev;
		begin
			case (sense)
				`PSC_SENSE_RISE: edge_hit = cur & ~prev;
				`PSC_SENSE_FALL: edge_hit = ~cur & prev;
				default:         edge_hit = 1'b0;
			endcase
		end
	endfunction

	// Three rear inputs plus outside clock, two-stage sync plus history
	// The third stage only keeps history for edge detection; nothing
	// but the second stage ever reads the first one.
	reg  [3:0] sync_a;
	reg  [3:0] sync_b;
	reg  [3:0] sync_c;
	wire [3:0] raw_in;
	assign raw_in = {i_outside_clock_input, i_break_input,
		i_stop_input, i_run_input};

	// R23: synchronise rear inputs
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
			always @(posedge i_clk) begin
				if (i_rst) begin
					sync_a[gi] <= 1'b0;
					sync_b[gi] <= 1'b0;
					sync_c[gi] <= 1'b0;
				end else if (i_ce) begin
					sync_a[gi] <= raw_in[gi];
					sync_b[gi] <= sync_a[gi];
					sync_c[gi] <= sync_b[gi];
				end
			end
		end
	endgenerate

	// Key edge detection; keys are level inputs, one action per press
	// A key held down acts once; it must be released to act again,
	// which keeps a slow operator from stepping many addresses.
	reg [4:0] key_prev;
	wire [4:0] key_now;
	wire [4:0] key_hit;
	assign key_now = {i_step_back_key, i_step_ahead_key, i_break_key,
		i_stop_key, i_run_key};
	assign key_hit = key_now & ~key_prev;

	always @(posedge i_clk) begin
		if (i_rst)
			key_prev <= 5'h00;
		else if (i_ce)
			key_prev <= key_now;
	end

	// Mode decode
	wire gated_mode;
	wire init_mode;
	assign gated_mode = (i_cycle_mode == `PSC_CYC_GATED) ||
		(i_cycle_mode == `PSC_CYC_INIT_GATE);
	assign init_mode = (i_cycle_mode == `PSC_CYC_INIT_GATE) ||
		(i_cycle_mode == `PSC_CYC_INIT_AUTO);

	// Qualified rear events; each edge lasts one cycle only
	wire run_edge;
	wire stop_edge;
	wire break_edge;
	wire gate_true;
	// R15: run input sense
	assign run_edge = edge_hit(i_run_sense, sync_b[0], sync_c[0]);
	// R16: stop input sense
	assign stop_edge = edge_hit(i_stop_sense, sync_b[1], sync_c[1]);
	// R17: break input sense
	assign break_edge = edge_hit(i_break_sense, sync_b[2], sync_c[2]);
	// Gate level is true in the sensed polarity, false when disabled
	// Limitation: a gate shorter than one clock may never be seen,
	// since it is taken from the synchronised level.
	assign gate_true = (i_run_sense == `PSC_SENSE_RISE) ? sync_b[0] :
		(i_run_sense == `PSC_SENSE_FALL) ? ~sync_b[0] : 1'b0;

	// R12: internal rate divider, tick every i_int_divide+1 cycles
	// A divide of zero advances on every clock; the counter width
	// sets the slowest internal rate.
	reg  [`PSC_DIV_W-1:0] div_cnt;
	wire                  int_tick;
	assign int_tick = (div_cnt >= i_int_divide);

	always @(posedge i_clk) begin
		if (i_rst)
			div_cnt <= {`PSC_DIV_W{1'b0}};
		else if (i_ce) begin
			if (int_tick)
				div_cnt <= {`PSC_DIV_W{1'b0}};
			else
				div_cnt <= div_cnt + 1'b1;
		end
	end

	// R13: outside clock edge choice
	// The outside clock is sampled, so it must stay well below half
	// the system clock; each edge then gives one advance.
	reg adv_tick;
	always @* begin
		case (i_clock_source)
			`PSC_CLK_INT:      adv_tick = int_tick;
			`PSC_CLK_EXT_RISE: adv_tick = sync_b[3] & ~sync_c[3];
			`PSC_CLK_EXT_FALL: adv_tick = ~sync_b[3] & sync_c[3];
			default:           adv_tick = 1'b0;
		endcase
	end

	wire manual;
	// R14: step keys only in manual clocking
	wire step_fwd;
	wire step_back;
	assign manual = (i_clock_source == `PSC_CLK_MANUAL);
	assign step_fwd = manual & key_hit[3];
	assign step_back = manual & key_hit[4] & ~gated_mode;

	// Sequencer state
	reg        preload;   // Still in the zero-to-start pass
	reg        finishing; // Gate fell; run on to window end
	reg        tick_clk;  // Clock phase, toggles per advance
	reg [1:0]  next_state;
	wire       running;
	wire       at_end;
	wire       step;
	assign running = (o_state == `PSC_ST_RUN);
	assign at_end = (o_address == i_window_end_address);
	// In manual run only forward keys advance
	assign step = running & (manual ? step_fwd : adv_tick);

	// Start requests
	wire start_req;
	// R5: run key ignored in gated modes
	// R8: key or run edge starts others
	// R3: single mode restarts only when stopped
	assign start_req = gated_mode ? (gate_true & ~running) :
		(key_hit[0] | run_edge) & ~running;

	// Strobe break fires on arrival at a marked address. After a resume
	// the sequencer must first leave that address, else it would break
	// again at once and never get past the mark.
	reg strobe_armed;
	always @(posedge i_clk) begin
		if (i_rst)
			strobe_armed <= 1'b1;
		else if (i_ce) begin
			if (o_state == `PSC_ST_BREAK)
				strobe_armed <= 1'b0;
			else if (step || o_state == `PSC_ST_STOP)
				strobe_armed <= 1'b1;
		end
	end

	// Break requests; R9: none in gated modes
	wire break_req;
	// R10: strobe one breaks on access
	assign break_req = ~gated_mode & running &
		(key_hit[2] | break_edge |
		(i_strobe_break_en & i_strobe_bit & strobe_armed));

	wire stop_req;
	assign stop_req = key_hit[1] | stop_edge;

	// End-of-window halt: single ends, gated finishes its last pass
	// A gate that falls mid-pass is remembered in finishing.
	wire halt_at_end;
	// R2: single halts at end
	// R4: gated finishes the window
	// R7: preload gated stops at end
	assign halt_at_end = (i_cycle_mode == `PSC_CYC_SINGLE) ||
		(gated_mode && (finishing || !gate_true));

	// Next operating state. Stop outranks break, break outranks start,
	// so a stop and a run request in one cycle leave the block stopped.
	always @* begin
		next_state = o_state;
		if (stop_req)
			next_state = `PSC_ST_STOP;
		else if (break_req)
			// Break holds the current address for a later resume
			next_state = `PSC_ST_BREAK;
		else if (start_req)
			next_state = `PSC_ST_RUN;
		else if (step && !preload && at_end && halt_at_end)
			// Last word of a pass that must not wrap
			next_state = `PSC_ST_STOP;
	end

	// Main state and address sequencing
	always @(posedge i_clk) begin
		if (i_rst) begin
			o_state   <= `PSC_ST_STOP;
			o_address <= `PSC_ADDR_ZERO;
			preload   <= 1'b0;
			finishing <= 1'b0;
			tick_clk  <= 1'b0;
		end else if (i_ce) begin
			// State follows the priority decode above; the branches
			// below keep address and phase in step with it
			o_state <= next_state;
			if (stop_req) begin
				// R22: address and word held on stop
				finishing <= 1'b0;
			end else if (break_req) begin
				// Break keeps address and phase as they stand
			end else if (start_req) begin
				finishing <= 1'b0;
				if (o_state == `PSC_ST_STOP) begin
					// R20: restart at window or zero
					if (init_mode) begin
						o_address <= `PSC_ADDR_ZERO;
						preload   <= 1'b1;
					end else begin
						o_address <= i_window_start_address;
						preload   <= 1'b0;
					end
				end
				// R21: break resume keeps address
			end else if (o_state == `PSC_ST_BREAK &&
				(step_fwd | step_back)) begin
				// R14: manual steps move address in break
				o_address <= step_fwd ? o_address + 1'b1 :
					o_address - 1'b1;
				tick_clk  <= ~tick_clk;
			end else if (step) begin
				tick_clk <= ~tick_clk;
				if (gated_mode && !gate_true)
					finishing <= 1'b1;
				// R6: preload pass reaches window start
				if (preload) begin
					if (o_address == i_window_start_address)
						preload <= 1'b0;
					else
						o_address <= o_address + 1'b1;
				end else if (at_end) begin
					// R1: wrap to window start unless halting
					if (!halt_at_end)
						o_address <= i_window_start_address;
				end else begin
					o_address <= o_address + 1'b1;
				end
			end
		end
	end

	// Clock outputs follow advance phase
	// Both lag the address by one cycle, so the word is settled
	// before the clock edge that a device under test will use.
	always @(posedge i_clk) begin
		if (i_rst) begin
			o_clock_one <= 1'b0;
			o_clock_two <= 1'b0;
		end else if (i_ce) begin
			o_clock_two <= tick_clk;
			// R11: clock one runs on in break
			if (o_state == `PSC_ST_BREAK && i_clock_one_in_break &&
				!gated_mode)
				o_clock_one <= int_tick ? ~o_clock_one : o_clock_one;
			else
				o_clock_one <= tick_clk;
		end
	end

	// Strobe output; pulse is one system cycle, the nearest to the width
	// At one advance per clock the pulses merge into a steady high,
	// a cost of keeping the output on the system clock.
	always @(posedge i_clk) begin
		if (i_rst)
			o_strobe_out <= 1'b0;
		else if (i_ce) begin
			if (i_strobe_clock_mode)
				// R19: narrow clock pulse per advance
				o_strobe_out <= step;
			else
				// R18: strobe bit as data channel
				o_strobe_out <= i_strobe_bit;
		end
	end

endmodule

// >>> psc_defs.vh
// Constants for the pattern sequencer control core
`ifndef PSC_DEFS_VH
`define PSC_DEFS_VH

`define PSC_AW            14
`define PSC_ADDR_ZERO     14'h0000
`define PSC_DIV_W         26

// Cycle mode encodings
`define PSC_CYC_AUTO      3'h0
`define PSC_CYC_SINGLE    3'h1
`define PSC_CYC_GATED     3'h2
`define PSC_CYC_INIT_GATE 3'h3
`define PSC_CYC_INIT_AUTO 3'h4

// Clock source encodings
`define PSC_CLK_INT       2'h0
`define PSC_CLK_EXT_RISE  2'h1
`define PSC_CLK_EXT_FALL  2'h2
`define PSC_CLK_MANUAL    2'h3

// Rear input sense encodings
`define PSC_SENSE_OFF     2'h0
`define PSC_SENSE_RISE    2'h1
`define PSC_SENSE_FALL    2'h2

// Operating states
`define PSC_ST_STOP       2'h0
`define PSC_ST_RUN        2'h1
`define PSC_ST_BREAK      2'h2

// Strobe output pulse: width in ns and cycles at 40 MHz
`define PSC_CLK_NS        25
`define PSC_STB_PULSE_NS  8
`define PSC_STB_PULSE_CYC 1

`endif

// >>> psc_far_side.sv
// Far side model: rear trigger pins and the strobe memory bit
module psc_far_side (
	input  wire        i_clk,
	input  wire [13:0] i_address,
	input  wire [13:0] i_mark,
	output reg         o_strobe_bit,
	output reg  [2:0]  o_pins
);
	timeunit 1ns;
	timeprecision 1ns;
	// Strobe memory holds a one at the marked address only
	always @* o_strobe_bit = (i_address === i_mark);
	// Rear pins idle low, like an open input
	initial o_pins = 3'h0;
	// Pin moves just after an edge; order is run, stop, break
	task set_pin(input int n, input logic v);
		@(posedge i_clk);
		#2;
		o_pins[n] = v;
	endtask
endmodule

// >>> psc_checker_sva.sv
// Port checker for the sequencer control core
`include "psc_defs.vh"
module psc_checker (
	input wire        i_clk,
	input wire        i_rst,
	input wire        i_ce,
	input wire [2:0]  i_cycle_mode,
	input wire [1:0]  i_clock_source,
	input wire [13:0] i_window_start_address,
	input wire [13:0] i_window_end_address,
	input wire        i_clock_one_in_break,
	input wire        i_run_key,
	input wire        i_stop_key,
	input wire [13:0] o_address,
	input wire [1:0]  o_state,
	input wire        o_clock_one,
	input wire        o_clock_two
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	// Mode groups; manual stepping may move an address held in break
	wire gated = i_cycle_mode == `PSC_CYC_GATED ||
		i_cycle_mode == `PSC_CYC_INIT_GATE;
	wire preload = i_cycle_mode == `PSC_CYC_INIT_AUTO ||
		i_cycle_mode == `PSC_CYC_INIT_GATE;
	wire man = i_clock_source == `PSC_CLK_MANUAL;
	wire auto_md = i_cycle_mode == `PSC_CYC_AUTO;
	AST_RUN_KEY: assert property ($rose(i_run_key) && i_ce && auto_md &&
		o_state == `PSC_ST_STOP && !i_stop_key |=> o_state == `PSC_ST_RUN)
		else $error("run key did not start");
	AST_STOP_KEY: assert property ($rose(i_stop_key) && i_ce
		|=> o_state == `PSC_ST_STOP) else $error("stop key ignored");
	AST_STOP_HOLD: assert property (o_state == `PSC_ST_STOP && !man &&
		$past(o_state) == `PSC_ST_STOP |-> $stable(o_address))
		else $error("address moved in stop");
	AST_START_ADDR: assert property ($past(o_state) == `PSC_ST_STOP &&
		o_state == `PSC_ST_RUN |-> o_address ===
		(preload ? `PSC_ADDR_ZERO : i_window_start_address))
		else $error("wrong start address");
	AST_GATED_NO_BREAK: assert property (gated && $past(gated) &&
		$past(o_state) != `PSC_ST_BREAK |-> o_state != `PSC_ST_BREAK)
		else $error("break in gated mode");
	AST_AUTO_WINDOW: assert property (o_state == `PSC_ST_RUN && auto_md &&
		$past(o_state) == `PSC_ST_RUN && $past(auto_md) |->
		o_address >= i_window_start_address &&
		o_address <= i_window_end_address) else $error("left window");
	AST_BREAK_HOLD: assert property (o_state == `PSC_ST_BREAK && !man &&
		$past(o_state) == `PSC_ST_BREAK |-> $stable(o_address) &&
		$stable(o_clock_two)) else $error("moved in break");
	AST_CLK1_BREAK: assert property (o_state == `PSC_ST_BREAK &&
		$past(o_state) == `PSC_ST_BREAK && !i_clock_one_in_break
		|-> $stable(o_clock_one)) else $error("clock one ran");
	AST_CE_FREEZE: assert property (!$past(i_ce) && !$past(i_rst) |->
		$stable(o_state) && $stable(o_address)) else $error("ran without ce");
endmodule

// >>> psc_pattern_sequencer_control_tb_top.sv
// Bench for the sequencer control core
module psc_pattern_sequencer_control_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	reg         i_clk = 0;
	reg         i_rst = 1;
	reg         i_ce = 1;
	reg  [2:0]  mode = 3'h0;
	reg  [1:0]  src = 2'h0;
	reg  [1:0]  sense = 2'h1;
	reg  [13:0] lo = 14'h0004;
	reg  [13:0] hi = 14'h0009;
	reg  [13:0] mark = 14'h3FFF;
	reg         sbrk = 0;
	reg         c1b = 0;
	reg  [4:0]  key = 5'h00; // run, stop, break, ahead, back
	reg         scm = 0;
	reg         oclk = 0;
	reg  [25:0] div = 26'h0000000;
	reg         v;
	reg         w;
	wire        clk1;
	wire        clk2;
	wire        sout;
	wire [2:0]  pins;
	wire        sbit;
	wire [13:0] addr;
	wire [1:0]  st;
	int         fails = 0;
	int         cmp_count = 0;
	always #12.5 i_clk = ~i_clk;
	// Divider starts at zero: one advance per cycle keeps runs short
	psc_pattern_sequencer_control i_psc_pattern_sequencer_control (
		.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_cycle_mode(mode),
		.i_clock_source(src), .i_int_divide(div),
		.i_window_start_address(lo), .i_window_end_address(hi),
		.i_strobe_break_en(sbrk), .i_clock_one_in_break(c1b),
		.i_strobe_clock_mode(scm), .i_run_sense(sense),
		.i_stop_sense(sense), .i_break_sense(sense),
		.i_run_input(pins[0]), .i_stop_input(pins[1]),
		.i_break_input(pins[2]), .i_outside_clock_input(oclk),
		.i_run_key(key[0]), .i_stop_key(key[1]), .i_break_key(key[2]),
		.i_step_ahead_key(key[3]), .i_step_back_key(key[4]),
		.i_strobe_bit(sbit), .o_address(addr), .o_state(st),
		.o_clock_one(clk1), .o_clock_two(clk2), .o_strobe_out(sout));
	psc_far_side i_psc_far_side (.i_clk(i_clk), .i_address(addr),
		.i_mark(mark), .o_strobe_bit(sbit), .o_pins(pins));
	// Compare one observed value
	task chk(input string what, input logic [13:0] exp, act);
		cmp_count++;
		if (act !== exp) begin
			fails++;
			$display("unexpected %s exp %h got %h", what, exp, act);
		end
	endtask
	// Hold one front key high for a single cycle
	task press(input int k);
		@(posedge i_clk);
		#2 key[k] = 1;
		@(posedge i_clk);
		#2 key[k] = 0;
	endtask
	// Bounded wait for a state, sampled after the edge settles
	task wait_st(input logic [1:0] s, input int n);
		repeat (n) if (st !== s) begin
			@(posedge i_clk);
			#1;
		end
	endtask
	task report_and_stop;
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Watchdog: the sequence needs well under a thousand cycles
	initial begin
		#75000;
		fails++;
		report_and_stop;
	end
	initial begin
		repeat (20) @(posedge i_clk);
		#2 i_rst = 0;
		chk("reset state", 14'h0000, st);
		press(0);
		wait_st(2'h1, 4);
		chk("auto run", 14'h0001, st);
		repeat (30) @(posedge i_clk);
		#2 i_ce = 0;
		repeat (3) @(posedge i_clk);
		#2 i_ce = 1;
		press(1);
		wait_st(2'h0, 4);
		chk("stopped", 14'h0000, st);
		mode = 3'h1;
		press(0);
		wait_st(2'h1, 4);
		wait_st(2'h0, 100);
		chk("single end", hi, addr);
		i_psc_far_side.set_pin(0, 1);
		wait_st(2'h1, 8);
		chk("rear run", 14'h0001, st);
		wait_st(2'h0, 100);
		chk("pass end", hi, addr);
		i_psc_far_side.set_pin(0, 0);
		// Let the fallen run pin pass the synchroniser before gating
		repeat (4) @(posedge i_clk);
		#2 mode = 3'h2;
		press(0);
		repeat (3) @(posedge i_clk);
		#2 chk("gated key", 14'h0000, st);
		i_psc_far_side.set_pin(0, 1);
		wait_st(2'h1, 8);
		press(2);
		repeat (3) @(posedge i_clk);
		#2 chk("gated run", 14'h0001, st);
		i_psc_far_side.set_pin(0, 0);
		wait_st(2'h0, 40);
		chk("gate end", hi, addr);
		mode = 3'h0;
		press(0);
		i_psc_far_side.set_pin(2, 1);
		wait_st(2'h2, 8);
		chk("rear break", 14'h0002, st);
		press(0);
		wait_st(2'h1, 4);
		i_psc_far_side.set_pin(1, 1);
		wait_st(2'h0, 8);
		chk("rear stop", 14'h0000, st);
		i_psc_far_side.set_pin(1, 0);
		i_psc_far_side.set_pin(2, 0);
		mark = 14'h0007;
		sbrk = 1;
		c1b = 1;
		press(0);
		wait_st(2'h2, 40);
		chk("strobe break", mark, addr);
		chk("strobe data", 14'h0001, sout);
		v = clk1;
		w = clk2;
		@(posedge i_clk);
		#2 chk("clock one", !v, clk1);
		chk("clock two", w, clk2);
		press(1);
		wait_st(2'h0, 4);
		mode = 3'h4;
		press(0);
		wait_st(2'h1, 4);
		chk("preload start", 14'h0000, addr);
		// Manual clocking with the strobe in clock mode
		press(1);
		wait_st(2'h0, 4);
		sbrk = 0;
		mode = 3'h0;
		src = 2'h3;
		scm = 1;
		press(0);
		wait_st(2'h1, 4);
		press(3);
		chk("manual step", 14'h0005, addr);
		chk("strobe pulse", 14'h0001, sout);
		@(posedge i_clk);
		#2 chk("pulse end", 14'h0000, sout);
		// Outside clock, rising then falling edge
		src = 2'h1;
		oclk = 1;
		repeat (4) @(posedge i_clk);
		#2 chk("outside rise", 14'h0006, addr);
		src = 2'h2;
		oclk = 0;
		repeat (4) @(posedge i_clk);
		#2 chk("outside fall", 14'h0007, addr);
		// Internal clock divided by three: two advances in six cycles
		src = 2'h0;
		div = 26'h0000002;
		repeat (6) @(posedge i_clk);
		#2 chk("divided rate", 14'h0009, addr);
		report_and_stop;
	end
endmodule
bind psc_pattern_sequencer_control psc_checker i_psc_checker (
	.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce),
	.i_cycle_mode(i_cycle_mode), .i_clock_source(i_clock_source),
	.i_window_start_address(i_window_start_address),
	.i_window_end_address(i_window_end_address),
	.i_clock_one_in_break(i_clock_one_in_break),
	.i_run_key(i_run_key), .i_stop_key(i_stop_key),
	.o_address(o_address), .o_state(o_state),
	.o_clock_one(o_clock_one), .o_clock_two(o_clock_two));
